// [hdl/atd_map.svh]
`ifndef ATD_MAP_SVH
`define ATD_MAP_SVH
`define ATD_OP_TIMER_CTL   10'h2aa
`define ATD_OP_PRESCALER   10'h235
`define ATD_OP_PULLUP_ZERO 10'h22d
`define ATD_OP_PULLUP_ONE  10'h22e
`define ATD_RST_TIMER_CTL  1'h0
`define ATD_RST_PRESCALER  8'h00
`define ATD_RST_PULLUP     4'h0
`define ATD_RST_FLAG       1'h0
`define ATD_ACC_TIMER_BIT  0
`endif

// [hdl/atd_pkg.sv]
package atd_pkg;
    typedef enum logic [4:0] {
        ATD_OP_NONE       = 5'h01,
        ATD_OP_TIMER      = 5'h02,
        ATD_OP_PRESCALE   = 5'h04,
        ATD_OP_PU_ZERO    = 5'h08,
        ATD_OP_PU_ONE     = 5'h10
    } atd_op_t;
endpackage

// [hdl/atd_decode.sv]
// Summary of operation
// (RULE_01) Opcode 2aa copies accumulator bit 0 into the timer control bit.
// (RULE_02) Opcode 235 loads B high nibble, A low nibble into prescaler and reload.
// (RULE_03) Opcode 22d copies the accumulator into pull-up control zero.
// (RULE_04) Opcode 22e copies the accumulator into pull-up control one.
// (RULE_05) Transfers never touch carry nor skip; destinations update at cycle end.
`include "atd_map.svh"

module atd_decode
    import atd_pkg::*;
(
    // Clock and reset.
    input  wire logic       clock,
    input  wire logic       nrst,
    // Instruction fetch side.
    input  wire logic       instr_valid,
    input  wire logic [9:0] instr_word,
    input  wire logic [3:0] acc,
    input  wire logic [3:0] reg_b,
    // Peripheral side.
    output logic            timer_control_bit_reg,
    output logic [7:0]      prescaler_reload_reg,
    output logic [7:0]      prescaler_counter,
    output logic            prescaler_load_reg,
    output logic [3:0]      pullup_control_zero,
    output logic [3:0]      pullup_control_one,
    // Core status side.
    output logic            carry_touch_reg,
    output logic            skip_next_reg
);

    function automatic atd_op_t decode_op(input logic v, input logic [9:0] w);
        decode_op = ATD_OP_NONE;
        if (v) begin
            case (w)
                `ATD_OP_TIMER_CTL:   decode_op = ATD_OP_TIMER;
                `ATD_OP_PRESCALER:   decode_op = ATD_OP_PRESCALE;
                `ATD_OP_PULLUP_ZERO: decode_op = ATD_OP_PU_ZERO;
                `ATD_OP_PULLUP_ONE:  decode_op = ATD_OP_PU_ONE;
                default:             decode_op = ATD_OP_NONE;
            endcase
        end
    endfunction

    atd_op_t op;
    assign op = decode_op(instr_valid, instr_word);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            timer_control_bit_reg <= `ATD_RST_TIMER_CTL;
        end else if (op == ATD_OP_TIMER) begin
            timer_control_bit_reg <= acc[`ATD_ACC_TIMER_BIT]; // RULE_01
        end
    end

    // The counter is only preset here; counting lives in the timer block, which
    // watches the load pulse so that its own count never fights this write.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            prescaler_reload_reg <= `ATD_RST_PRESCALER;
            prescaler_counter    <= `ATD_RST_PRESCALER;
        end else if (op == ATD_OP_PRESCALE) begin
            prescaler_reload_reg <= {reg_b, acc}; // RULE_02
            prescaler_counter    <= {reg_b, acc}; // RULE_02
        end
    end

    // Back-to-back loads keep the pulse high, one cycle for each load taken.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            prescaler_load_reg <= `ATD_RST_FLAG;
        end else begin
            prescaler_load_reg <= (op == ATD_OP_PRESCALE); // RULE_02
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            pullup_control_zero <= `ATD_RST_PULLUP;
        end else if (op == ATD_OP_PU_ZERO) begin
            pullup_control_zero <= acc; // RULE_03
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            pullup_control_one <= `ATD_RST_PULLUP;
        end else if (op == ATD_OP_PU_ONE) begin
            pullup_control_one <= acc; // RULE_04
        end
    end

    // These instructions own no flags, so both status outputs stay low.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            carry_touch_reg <= `ATD_RST_FLAG;
            skip_next_reg   <= `ATD_RST_FLAG;
        end else begin
            carry_touch_reg <= 1'h0; // RULE_05
            skip_next_reg   <= 1'h0; // RULE_05
        end
    end

    timer_copy_a: assert property (@(posedge clock) disable iff (!nrst) // RULE_01
        (instr_valid && instr_word == `ATD_OP_TIMER_CTL) |=> timer_control_bit_reg == $past(acc[0]))
        else $error("Timer control bit not copied from accumulator.");

    sequence prescale_issue;
        instr_valid && instr_word == `ATD_OP_PRESCALER;
    endsequence

    prescale_load_a: assert property (@(posedge clock) disable iff (!nrst) // RULE_02
        prescale_issue |=> prescaler_reload_reg == {$past(reg_b), $past(acc)}
                           && prescaler_counter == prescaler_reload_reg && prescaler_load_reg)
        else $error("Prescaler pair not loaded from B and accumulator.");

    pullup_zero_a: assert property (@(posedge clock) disable iff (!nrst) // RULE_03
        (instr_valid && instr_word == `ATD_OP_PULLUP_ZERO) |=> pullup_control_zero == $past(acc))
        else $error("Pull-up control zero not written.");

    pullup_one_a: assert property (@(posedge clock) disable iff (!nrst) // RULE_04
        (instr_valid && instr_word == `ATD_OP_PULLUP_ONE) |=> pullup_control_one == $past(acc))
        else $error("Pull-up control one not written.");

    pullup_hold_a: assert property (@(posedge clock) disable iff (!nrst) // RULE_03
        !(instr_valid && instr_word == `ATD_OP_PULLUP_ZERO) |=> $stable(pullup_control_zero))
        else $error("Pull-up control zero changed without its opcode.");

    timer_hold_a: assert property (@(posedge clock) disable iff (!nrst) // RULE_01
        !(instr_valid && instr_word == `ATD_OP_TIMER_CTL) |=> $stable(timer_control_bit_reg))
        else $error("Timer control bit changed without its opcode.");

    prescale_pulse_a: assert property (@(posedge clock) disable iff (!nrst) // RULE_02
        prescaler_load_reg |-> $past(instr_valid) && $past(instr_word) == `ATD_OP_PRESCALER)
        else $error("Prescaler load pulse without its opcode.");

    no_flags_a: assert property (@(posedge clock) disable iff (!nrst) // RULE_05
        prescale_issue |=> !carry_touch_reg && !skip_next_reg)
        else $error("Transfer touched carry or skip.");

    sequence timer_issue;
        instr_valid && instr_word == `ATD_OP_TIMER_CTL;
    endsequence

    sequence pullup_zero_issue;
        instr_valid && instr_word == `ATD_OP_PULLUP_ZERO;
    endsequence

    sequence pullup_one_issue;
        instr_valid && instr_word == `ATD_OP_PULLUP_ONE;
    endsequence

    sequence refused_issue;
        !instr_valid;
    endsequence

    sequence prescale_twice;
        prescale_issue ##1 prescale_issue;
    endsequence

    pullup_one_hold_a: assert property (@(posedge clock) disable iff (!nrst) // RULE_04
        !(instr_valid && instr_word == `ATD_OP_PULLUP_ONE) |=> $stable(pullup_control_one))
        else $error("Pull-up control one changed without its opcode.");

    prescale_hold_a: assert property (@(posedge clock) disable iff (!nrst) // RULE_02
        !(instr_valid && instr_word == `ATD_OP_PRESCALER)
        |=> $stable(prescaler_reload_reg) && $stable(prescaler_counter) && !prescaler_load_reg)
        else $error("Prescaler pair changed without its opcode.");

    prescale_counter_a: assert property (@(posedge clock) disable iff (!nrst) // RULE_02
        prescale_issue |=> prescaler_counter == {$past(reg_b), $past(acc)})
        else $error("Prescaler counter not preset from B and accumulator.");

    prescale_twice_a: assert property (@(posedge clock) disable iff (!nrst) // RULE_02
        prescale_twice |=> prescaler_load_reg && prescaler_counter == {$past(reg_b), $past(acc)})
        else $error("Second back-to-back prescaler load lost.");

    timer_isolate_a: assert property (@(posedge clock) disable iff (!nrst) // RULE_01
        timer_issue |=> $stable(prescaler_reload_reg) && $stable(pullup_control_zero)
                        && $stable(pullup_control_one) && !prescaler_load_reg)
        else $error("Timer transfer disturbed another destination.");

    pullup_zero_isolate_a: assert property (@(posedge clock) disable iff (!nrst) // RULE_03
        pullup_zero_issue |=> $stable(pullup_control_one) && $stable(timer_control_bit_reg)
                              && $stable(prescaler_reload_reg))
        else $error("Pull-up zero transfer disturbed another destination.");

    pullup_one_isolate_a: assert property (@(posedge clock) disable iff (!nrst) // RULE_04
        pullup_one_issue |=> $stable(pullup_control_zero) && $stable(timer_control_bit_reg)
                             && $stable(prescaler_reload_reg))
        else $error("Pull-up one transfer disturbed another destination.");

    timer_flags_a: assert property (@(posedge clock) disable iff (!nrst) // RULE_05
        timer_issue |=> !carry_touch_reg && !skip_next_reg)
        else $error("Timer transfer touched carry or skip.");

    pullup_zero_flags_a: assert property (@(posedge clock) disable iff (!nrst) // RULE_05
        pullup_zero_issue |=> !carry_touch_reg && !skip_next_reg)
        else $error("Pull-up zero transfer touched carry or skip.");

    pullup_one_flags_a: assert property (@(posedge clock) disable iff (!nrst) // RULE_05
        pullup_one_issue |=> !carry_touch_reg && !skip_next_reg)
        else $error("Pull-up one transfer touched carry or skip.");

    // Nothing is signalled for a refused cycle; the only sign is that nothing moves.
    refused_hold_a: assert property (@(posedge clock) disable iff (!nrst) // RULE_05
        refused_issue |=> $stable(timer_control_bit_reg) && $stable(prescaler_reload_reg)
                          && $stable(pullup_control_zero) && $stable(pullup_control_one)
                          && !prescaler_load_reg)
        else $error("Destination changed while no instruction was valid.");

    refused_flags_a: assert property (@(posedge clock) disable iff (!nrst) // RULE_05
        refused_issue |=> !carry_touch_reg && !skip_next_reg)
        else $error("Idle cycle touched carry or skip.");

    // Reset checks carry no disable, since they watch the reset itself.
    reset_clear_a: assert property (@(posedge clock)
        !nrst |=> timer_control_bit_reg == `ATD_RST_TIMER_CTL && prescaler_reload_reg == `ATD_RST_PRESCALER
                  && prescaler_counter == `ATD_RST_PRESCALER && pullup_control_zero == `ATD_RST_PULLUP
                  && pullup_control_one == `ATD_RST_PULLUP)
        else $error("Destination not cleared by reset.");

    reset_flags_a: assert property (@(posedge clock)
        !nrst |=> prescaler_load_reg == `ATD_RST_FLAG && carry_touch_reg == `ATD_RST_FLAG
                  && skip_next_reg == `ATD_RST_FLAG)
        else $error("Status flag not cleared by reset.");

endmodule

// [sim/atd_fetch_model.sv]
module atd_fetch_model (
    // Clock.
    input  wire logic clock,
    // Fetch outputs.
    output logic       instr_valid,
    output logic [9:0] instr_word,
    output logic [3:0] acc,
    output logic [3:0] reg_b
);
    timeunit 1ns;
    timeprecision 1ps;
    initial instr_valid = 1'h0;
    // Presents one instruction word per cycle, moving only after an edge.
    task automatic issue(input logic v, input logic [9:0] w, input logic [3:0] a, input logic [3:0] b);
        @(posedge clock);
        instr_valid <= v;
        instr_word <= w;
        acc <= a;
        reg_b <= b;
    endtask
endmodule

// [sim/tb_top.sv]
`include "atd_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'h0;
    logic        nrst = 1'h0;
    logic        iv, tc, pl, ct, sk, et, vld;
    logic        seen = 1'h0;
    logic        slot = 1'h0;
    logic [9:0]  iw;
    logic [3:0]  a, b, p0, p1, e0, e1;
    logic [7:0]  rl, pc, ep;
    logic [27:0] exp_q[$];
    int          err_total = 0, comparisons = 0, seed = 41259, sel;
    logic [9:0]  ops[4] = '{`ATD_OP_TIMER_CTL, `ATD_OP_PRESCALER, `ATD_OP_PULLUP_ZERO, `ATD_OP_PULLUP_ONE};
    wire [27:0]  got = {tc, rl, pc, pl, p0, p1, ct, sk};
    initial forever #2 clock = ~clock;
    atd_fetch_model i_atd_fetch_model (.clock(clock), .instr_valid(iv), .instr_word(iw), .acc(a), .reg_b(b));
    atd_decode i_atd_decode (.clock(clock), .nrst(nrst), .instr_valid(iv), .instr_word(iw), .acc(a), .reg_b(b),
        .timer_control_bit_reg(tc), .prescaler_reload_reg(rl), .prescaler_counter(pc), .prescaler_load_reg(pl),
        .pullup_control_zero(p0), .pullup_control_one(p1), .carry_touch_reg(ct), .skip_next_reg(sk));
    task automatic chk(input logic [27:0] e, input logic [27:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] outputs exp %h got %h", e, g);
        end
    endtask
    task automatic give_verdict();
        if (exp_q.size() != 0) begin
            err_total++;
            $display("[ERR] pending_notes exp 0 got %0d", exp_q.size());
        end
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Unknown opcodes fall to the default arm, so they must leave every destination alone.
    // A cycle without valid must leave every destination alone as well.
    task automatic run(input logic v, input logic [9:0] w, input logic [3:0] ra, input logic [3:0] rb);
        i_atd_fetch_model.issue(v, w, ra, rb);
        slot <= 1'h1;
        if (v) begin
            case (w)
                `ATD_OP_TIMER_CTL: et = ra[0];
                `ATD_OP_PRESCALER: ep = {rb, ra};
                `ATD_OP_PULLUP_ZERO: e0 = ra;
                `ATD_OP_PULLUP_ONE: e1 = ra;
                default: ;
            endcase
        end
        exp_q.push_back({et, ep, ep, v && w == `ATD_OP_PRESCALER, e0, e1, 2'h0});
    endtask
    always @(posedge clock) seen <= slot & nrst;
    always @(negedge clock) if (seen) chk(exp_q.pop_front(), got);
    // The second pass starts from a mid-run reset, so written values must clear to zero.
    initial begin
        repeat (20) @(posedge clock);
        for (int pass = 0; pass < 2; pass++) begin
            nrst <= 1'h1;
            @(negedge clock);
            et = `ATD_RST_TIMER_CTL;
            ep = `ATD_RST_PRESCALER;
            e0 = `ATD_RST_PULLUP;
            e1 = `ATD_RST_PULLUP;
            chk({et, ep, ep, 1'h0, e0, e1, 2'h0}, got);
            for (int i = 0; i < 150; i++) begin
                sel = {$random(seed)} % 6;
                vld = ({$random(seed)} % 8) != 0;
                run(vld, sel < 4 ? ops[sel] : 10'($random(seed)), 4'($random(seed)), 4'($random(seed)));
            end
            i_atd_fetch_model.issue(1'h0, 10'h0, 4'h0, 4'h0);
            slot <= 1'h0;
            repeat (2) @(posedge clock);
            nrst <= 1'h0;
            repeat (2) @(posedge clock);
        end
        give_verdict();
    end
    initial begin
        #8000;
        err_total++;
        give_verdict();
    end
endmodule
